// *** verilog/pdmw_pkg.sv ***
// Constants, types and decode helpers for the power-down and wakeup block
package pdmw_pkg;
  // ==========================================================
  // Widths
  localparam int PORT_W = 8;
  localparam int MODE_W = 4;
  localparam int PC_W = 11;
  localparam int WDOG_W = 8;
  // ==========================================================
  // Port access select codes
  localparam logic [MODE_W-1:0] SEL_DIR = 4'hF;
  localparam logic [MODE_W-1:0] SEL_EDGE = 4'hA;
  localparam logic [MODE_W-1:0] SEL_PEND = 4'h9;
  localparam logic [MODE_W-1:0] SEL_WKEN = 4'hB;
  // ==========================================================
  // Reset values, wake address and watchdog step
  localparam logic [PORT_W-1:0] WKEN_RST = 8'hFF;
  localparam logic [PORT_W-1:0] WKED_RST = 8'hFF;
  localparam logic [PORT_W-1:0] PEND_RST = 8'h00;
  localparam logic [PORT_W-1:0] DIR_RST = 8'hFF;
  localparam logic [PORT_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [PC_W-1:0] PC_TOP = 11'h7FF;
  localparam logic [PC_W-1:0] PC_RST = 11'h000;
  localparam logic [WDOG_W-1:0] WDOG_RST = 8'h00;
  localparam logic [WDOG_W-1:0] WDOG_ONE = 8'h01;
  localparam logic FLAG_EXPIRY_RST = 1'b1;
  localparam logic FLAG_PWRDN_RST = 1'b1;
  // ==========================================================
  // Types
  typedef enum {PDMW_RUN, PDMW_SLEEP} pdmw_state_t;
  // ==========================================================
  // Decode
  function automatic logic pdmw_sel(input logic [MODE_W-1:0] mode,
                                    input logic [MODE_W-1:0] code);
    return mode == code;
  endfunction : pdmw_sel
endpackage : pdmw_pkg

// *** verilog/pdmw_wake_if.sv ***
// Signals between the controller and the edge detector
`timescale 1ns/100ps
interface pdmw_wake_if;
  import pdmw_pkg::*;
  logic [PORT_W-1:0] pins;
  logic [PORT_W-1:0] edge_sel;
  logic [PORT_W-1:0] en_n;
  logic [PORT_W-1:0] pend_wdata;
  logic pend_wr;
  logic [PORT_W-1:0] pending;
  logic wake_req;
  modport ctrl (output pins, output edge_sel, output en_n, output pend_wdata,
                output pend_wr, input pending, input wake_req);
  modport det (input pins, input edge_sel, input en_n, input pend_wdata,
               input pend_wr, output pending, output wake_req);
endinterface : pdmw_wake_if

// *** verilog/pdmw_edge_det.sv ***
// Per-pin edge detection, pending latch and wake request
`timescale 1ns/100ps
module pdmw_edge_det (
  input wire logic clk_i,
  input wire logic arst_n_i,
  pdmw_wake_if.det wk
);
  import pdmw_pkg::*;

  logic [PORT_W-1:0] prev_reg;
  logic [PORT_W-1:0] pend_reg;
  logic [PORT_W-1:0] pend_next;
  logic [PORT_W-1:0] hit;
  logic wake_reg;

  // ==========================================================
  // Edge select per pin
  genvar g;
  generate
    for (g = 0; g < PORT_W; g++) begin : g_pin
      assign hit[g] = wk.edge_sel[g] ? (prev_reg[g] & ~wk.pins[g])
                                     : (~prev_reg[g] & wk.pins[g]);
    end
  endgenerate

  // Edge set wins over a software write
  assign pend_next = (wk.pend_wr ? wk.pend_wdata : pend_reg) | hit;

  // ==========================================================
  // Sampling runs whatever the core does
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev_reg <= ZERO_BYTE;
    end else begin
      prev_reg <= wk.pins;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_reg <= PEND_RST;
    end else begin
      pend_reg <= pend_next;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= |(pend_reg & ~wk.en_n);
    end
  end

  assign wk.pending = pend_reg;
  assign wk.wake_req = wake_reg;

  // ==========================================================
  // Checks
  a_rise_latch: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (!wk.edge_sel[0] && !prev_reg[0] && wk.pins[0]) |=> pend_reg[0])
    else $error("rising edge not latched");
  a_pend_sticky: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (pend_reg[0] && !wk.pend_wr) |=> pend_reg[0])
    else $error("pending bit dropped without write");
  a_wake_mask: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ##1 wake_reg == $past(|(pend_reg & ~wk.en_n)))
    else $error("wake request mismatch");
endmodule : pdmw_edge_det

// *** verilog/pdmw_top.sv ***
// Power-down control with eight-pin multi-input wakeup
`timescale 1ns/100ps
// Contract
// - Sleep instruction enters power-down
// - Power-down halts all but watchdog; the code halts only the core (core_halt_o), edge detection keeps running
// - Sleep with watchdog: clear count, flags
// - Exit only on watchdog, pin, reset
// - Active-low enable bit per pin
// - Edge select: set falling, clear rising
// - Reset loads enable and edge all ones
// - Selected edge latches pending bit
// - Wakeup loads program counter top address
// - Pending selected: move exchanges values
// - Select code routes special-path write
// - Interrupts share pending and detection
module pdmw_top #(
  parameter int WDOG_BITS = pdmw_pkg::WDOG_W
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic sleep_exec_i,
  input wire logic wdog_enable_i,
  input wire logic external_reset_pin_n_i,
  input wire logic [pdmw_pkg::PORT_W-1:0] port_b_pins_i,
  input wire logic [pdmw_pkg::MODE_W-1:0] port_mode_i,
  input wire logic port_wr_i,
  input wire logic port_xchg_i,
  input wire logic [pdmw_pkg::PORT_W-1:0] acc_i,
  output logic [pdmw_pkg::PORT_W-1:0] rd_data_o,
  output logic [pdmw_pkg::PORT_W-1:0] port_b_dir_o,
  output logic core_halt_o,
  output logic pc_load_o,
  output logic [pdmw_pkg::PC_W-1:0] pc_value_o,
  output logic watchdog_expiry_flag_o,
  output logic power_down_flag_o,
  output logic ext_irq_o
);
  import pdmw_pkg::*;

  pdmw_wake_if wk ();

  pdmw_state_t state_reg;
  logic [PORT_W-1:0] wake_enable_n_reg;
  logic [PORT_W-1:0] wake_edge_select_reg;
  logic [WDOG_BITS-1:0] watchdog_counter_reg;
  logic any_access;
  logic wdog_ovf;
  logic wake_now;
  logic first_reg;

  assign any_access = port_wr_i | port_xchg_i;
  assign wdog_ovf = wdog_enable_i & (&watchdog_counter_reg);
  assign wake_now = wdog_ovf | wk.wake_req | ~external_reset_pin_n_i;

  // ==========================================================
  // Detector hookup
  assign wk.pins = port_b_pins_i;
  assign wk.edge_sel = wake_edge_select_reg;
  assign wk.en_n = wake_enable_n_reg;
  assign wk.pend_wdata = acc_i;
  assign wk.pend_wr = any_access & pdmw_sel(port_mode_i, SEL_PEND);

  pdmw_edge_det u_det (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .wk(wk.det)
  );

  // ==========================================================
  // Port configuration registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wake_enable_n_reg <= WKEN_RST;
      wake_edge_select_reg <= WKED_RST;
      port_b_dir_o <= DIR_RST;
    end else if (any_access) begin
      if (pdmw_sel(port_mode_i, SEL_WKEN)) begin
        wake_enable_n_reg <= acc_i;
      end
      if (pdmw_sel(port_mode_i, SEL_EDGE)) begin
        wake_edge_select_reg <= acc_i;
      end
      if (pdmw_sel(port_mode_i, SEL_DIR)) begin
        port_b_dir_o <= acc_i;
      end
    end
  end

  // Exchange returns old pending value
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_data_o <= ZERO_BYTE;
    end else if (port_xchg_i && pdmw_sel(port_mode_i, SEL_PEND)) begin
      rd_data_o <= wk.pending;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_irq_o <= 1'b0;
    end else begin
      ext_irq_o <= wk.wake_req;
    end
  end

  // ==========================================================
  // Watchdog keeps counting in power-down
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      watchdog_counter_reg <= WDOG_BITS'(WDOG_RST);
    end else if (sleep_exec_i && wdog_enable_i && state_reg == PDMW_RUN) begin
      watchdog_counter_reg <= WDOG_BITS'(WDOG_RST);
    end else if (wdog_enable_i) begin
      watchdog_counter_reg <= watchdog_counter_reg + WDOG_BITS'(WDOG_ONE);
    end
  end

  // ==========================================================
  // Power state
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= PDMW_RUN;
      core_halt_o <= 1'b0;
    end else begin
      case (state_reg)
        PDMW_RUN: begin
          if (sleep_exec_i) begin
            state_reg <= PDMW_SLEEP;
            core_halt_o <= 1'b1;
          end
        end
        PDMW_SLEEP: begin
          if (wake_now) begin
            state_reg <= PDMW_RUN;
            core_halt_o <= 1'b0;
          end
        end
        default: begin
          state_reg <= PDMW_RUN;
          core_halt_o <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pc_load_o <= 1'b0;
      pc_value_o <= PC_RST;
    end else begin
      pc_load_o <= state_reg == PDMW_SLEEP && wake_now;
      pc_value_o <= PC_TOP;
    end
  end

  // ==========================================================
  // Status flags
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      watchdog_expiry_flag_o <= FLAG_EXPIRY_RST;
      power_down_flag_o <= FLAG_PWRDN_RST;
    end else if (sleep_exec_i && wdog_enable_i && state_reg == PDMW_RUN) begin
      watchdog_expiry_flag_o <= 1'b1;
      power_down_flag_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      first_reg <= 1'b1;
    end else begin
      first_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  a_sleep_entry: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (state_reg == PDMW_RUN && sleep_exec_i) |=> core_halt_o)
    else $error("sleep not entered");
  a_halt_holds: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (core_halt_o && !wake_now) |=> core_halt_o)
    else $error("halt released without cause");
  a_wdog_cleared: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (state_reg == PDMW_RUN && sleep_exec_i && wdog_enable_i)
      |=> watchdog_counter_reg == '0 && watchdog_expiry_flag_o && !power_down_flag_o)
    else $error("sleep flags or watchdog wrong");
  a_wake_cause: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $fell(core_halt_o) |-> $past(wake_now))
    else $error("wake without cause");
  a_pc_reload: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $fell(core_halt_o) |-> pc_load_o ##1 !pc_load_o)
    else $error("program counter not reloaded");
  a_pc_value: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    pc_load_o |-> pc_value_o == PC_TOP)
    else $error("wrong wake address");
  a_reset_vals: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    first_reg |-> wake_enable_n_reg == WKEN_RST && wake_edge_select_reg == WKED_RST)
    else $error("wake registers not reset to ones");
  a_xchg_read: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (port_xchg_i && pdmw_sel(port_mode_i, SEL_PEND)) |=> rd_data_o == $past(wk.pending))
    else $error("exchange returned wrong value");
  a_wken_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (port_wr_i && pdmw_sel(port_mode_i, SEL_WKEN)) |=> wake_enable_n_reg == $past(acc_i))
    else $error("enable write misrouted");
  a_edge_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (any_access && pdmw_sel(port_mode_i, SEL_EDGE)) |=> wake_edge_select_reg == $past(acc_i))
    else $error("edge select write misrouted");
  a_flags_keep: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !(state_reg == PDMW_RUN && sleep_exec_i && wdog_enable_i)
      |=> $stable(watchdog_expiry_flag_o) && $stable(power_down_flag_o))
    else $error("status flags changed without sleep");
  a_pin_reset_wake: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (core_halt_o && !external_reset_pin_n_i) |=> !core_halt_o && pc_load_o)
    else $error("external reset pin did not wake");

  c_sleep: cover property (@(posedge clk_i) disable iff (!arst_n_i) $rose(core_halt_o));
  c_pin_wake: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    core_halt_o && wk.wake_req);
  c_wdog_wake: cover property (@(posedge clk_i) disable iff (!arst_n_i) core_halt_o && wdog_ovf);
  c_xchg: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    port_xchg_i && pdmw_sel(port_mode_i, SEL_PEND));
endmodule : pdmw_top

// *** bench/pdmw_pin_src.sv ***
// Port B pin source model
`timescale 1ns/100ps
module pdmw_pin_src (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] flip_i,
  output logic [7:0] pins_o
);
  // ==========================================================
  // Pin levels, toggled on request
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) pins_o <= 8'h00;
    else pins_o <= pins_o ^ flip_i;
  end
endmodule : pdmw_pin_src

// *** bench/pdmw_top_test.sv ***
// Self-checking bench for the power-down and wakeup block
`timescale 1ns/100ps
module pdmw_top_test;
  import pdmw_pkg::*;
  typedef struct packed {logic k; logic [10:0] v;} pdmw_note_t;
  logic clk_i = 0, arst_n_i = 0, slp = 0, wden = 0, xr_n = 1, wr = 0, xg = 0, xp = 0;
  logic [3:0] mode = 4'h0;
  logic [7:0] acc = 8'h00, flip = 8'h00, pins, rd, dir, e, m, p, a, pv;
  logic halt, pcl, exp_f, pwd_f, irq;
  logic [1:0] fl = 2'b11;
  logic [10:0] pcv;
  int err_total = 0, n_compared = 0;
  pdmw_note_t q[$];
  pdmw_note_t n;
  pdmw_pin_src src (.clk_i(clk_i), .arst_n_i(arst_n_i), .flip_i(flip), .pins_o(pins));
  pdmw_top #(.WDOG_BITS(4)) dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .sleep_exec_i(slp),
    .wdog_enable_i(wden), .external_reset_pin_n_i(xr_n), .port_b_pins_i(pins),
    .port_mode_i(mode), .port_wr_i(wr), .port_xchg_i(xg), .acc_i(acc), .rd_data_o(rd),
    .port_b_dir_o(dir), .core_halt_o(halt), .pc_load_o(pcl), .pc_value_o(pcv),
    .watchdog_expiry_flag_o(exp_f), .power_down_flag_o(pwd_f), .ext_irq_o(irq));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  // ==========================================================
  // Shared tasks
  task automatic chk(input string s, input logic [10:0] x, input logic [10:0] y);
    n_compared++;
    if (x !== y) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", s, x, y);
    end
  endtask : chk
  task automatic print_verdict;
    if (err_total == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  task automatic acc_op(input logic x, input logic [3:0] md, input logic [7:0] d);
    @(posedge clk_i);
    wr <= !x;
    xg <= x;
    mode <= md;
    acc <= d;
    @(posedge clk_i);
    wr <= 1'b0;
    xg <= 1'b0;
  endtask : acc_op
  task automatic xchg(input logic [7:0] d, input logic [7:0] ex);
    q.push_back('{1'b0, {3'h0, ex}});
    acc_op(1'b1, SEL_PEND, d);
  endtask : xchg
  task automatic pin_flip(input logic [7:0] f);
    @(posedge clk_i);
    flip <= f;
    @(posedge clk_i);
    flip <= 8'h00;
    repeat (3) @(posedge clk_i);
  endtask : pin_flip
  task automatic nap(input logic w);
    @(posedge clk_i);
    wden <= w;
    slp <= 1'b1;
    @(posedge clk_i);
    slp <= 1'b0;
    #1;
    if (w) fl = 2'b10;
    chk("core_halt_o", 1, halt);
    chk("flags", fl, {exp_f, pwd_f});
  endtask : nap
  task automatic wait_wake(input int lim);
    for (int i = 0; i < lim && halt !== 1'b0; i++) @(posedge clk_i);
    #1;
    chk("core_halt_o", 0, halt);
    if (halt !== 1'b0) print_verdict();
  endtask : wait_wake
  // ==========================================================
  // Result watcher
  always @(posedge clk_i) begin
    if (pcl === 1'b1 || xp) begin
      if (q.size() == 0) begin
        chk("pc_load_o", 0, 1);
      end else begin
        n = q.pop_front();
        chk(n.k ? "pc_value_o" : "rd_data_o", n.v, n.k ? pcv : {3'h0, rd});
      end
    end
    xp <= xg === 1'b1 && mode === SEL_PEND;
  end
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'hbb32bc53));
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
    chk("port_b_dir_o", 8'hFF, dir);
    chk("pc_value_o", PC_TOP, pcv);
    chk("flags", 2'b11, {exp_f, pwd_f});
    m = 8'($urandom) | 8'h01;
    pin_flip(m);
    pin_flip(m);
    chk("ext_irq_o", 0, irq);
    xchg(8'h00, m);
    pv = 8'h00;
    for (int i = 0; i < 4; i++) begin
      e = 8'($urandom) & 8'hFE;
      m = 8'($urandom) | 8'h01;
      a = 8'($urandom);
      p = pins;
      acc_op(i[0], SEL_EDGE, e);
      pin_flip(m);
      xchg(a, pv | (m & ~(e ^ p)));
      pv = a;
    end
    xchg(8'h00, pv);
    xchg(8'h01, 8'h00);
    acc_op(1'b0, SEL_WKEN, 8'hFD);
    repeat (3) @(posedge clk_i);
    chk("ext_irq_o", 0, irq);
    acc_op(1'b0, SEL_WKEN, 8'hFE);
    repeat (3) @(posedge clk_i);
    chk("ext_irq_o", 1, irq);
    a = 8'($urandom);
    acc_op(1'b0, SEL_DIR, a);
    acc_op(1'b0, 4'h3, ~a);
    #1;
    chk("port_b_dir_o", a, dir);
    acc_op(1'b0, SEL_EDGE, pins);
    xchg(8'h00, 8'h01);
    nap(1'b0);
    pin_flip(8'h02);
    chk("core_halt_o", 1, halt);
    q.push_back('{1'b1, PC_TOP});
    pin_flip(8'h01);
    wait_wake(10);
    xchg(8'h00, 8'h03);
    acc_op(1'b0, SEL_WKEN, 8'hFF);
    nap(1'b1);
    repeat (10) @(posedge clk_i);
    chk("core_halt_o", 1, halt);
    q.push_back('{1'b1, PC_TOP});
    wait_wake(40);
    nap(1'b0);
    q.push_back('{1'b1, PC_TOP});
    @(posedge clk_i);
    xr_n <= 1'b0;
    wait_wake(10);
    @(posedge clk_i);
    xr_n <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("notes_left", 0, 11'(q.size()));
    print_verdict();
  end
endmodule : pdmw_top_test
